// file: cdi_pkg.sv
// Constants and types shared by the card detect and interrogation block.
// Assumes a single 10 MHz system clock and an active-low asynchronous reset.
// Contract
// - 5 V-only socket always powers at 5 V.
// - On removal drop supplies, float card signals.
// - Sense inputs valid only with both detects low.
// - Supportable requested supply may be switched on.
// - Unsupported supply: stay unpowered, undriven, notify.
// - Without type-B support, assume 16-bit card.
// - One detect low may flag mis-insertion.
// - Valid insertion needs both debounced detects low.
// - Type-B socket drives sense low on removal.
// - Probe by raising each sense output alternately.
// - Sense outputs low except while probing.
// - Identify card type before signalling insertion.
// - Programming supplies stay at sensed level initially.
package cdi_pkg;

  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned PROBE_SETTLE_NS = 500;
  localparam int unsigned DEBOUNCE_NS     = 1000000;
  localparam logic [3:0]  PROBE_CYC       =
    4'((PROBE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] DEBOUNCE_CYC    = 16'(DEBOUNCE_NS / CLK_PERIOD_NS);

  // Supply level one-hot bits, also used as the supported-supply code.
  localparam logic [3:0] SUP_NONE = 4'h0;
  localparam logic [3:0] SUP_5V   = 4'h1;
  localparam logic [3:0] SUP_3V3  = 4'h2;
  localparam logic [3:0] SUP_XV   = 4'h4;
  localparam logic [3:0] SUP_YV   = 4'h8;

  localparam logic [1:0] TYPE_NONE  = 2'h0;
  localparam logic [1:0] TYPE_16BIT = 2'h1;
  localparam logic [1:0] TYPE_B     = 2'h2;
  localparam logic [1:0] TYPE_RSVD  = 2'h3;

  // Sample word layout: {detect2, detect1, sense2, sense1}.
  localparam int unsigned SMP_VS1 = 0;
  localparam int unsigned SMP_VS2 = 1;
  localparam int unsigned SMP_CD1 = 2;
  localparam int unsigned SMP_CD2 = 3;

  localparam logic [1:0] SENSE_LOW   = 2'h0;
  localparam logic [1:0] SENSE_HI1   = 2'h1;
  localparam logic [1:0] SENSE_HI2   = 2'h2;
  localparam logic [1:0] DET_BOTH_LO = 2'h0;
  localparam logic [1:0] DET_BOTH_HI = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE, ST_PROBE1, ST_PROBE2, ST_DECIDE, ST_POWERED, ST_REJECT
  } cdi_state_t;

endpackage : cdi_pkg

// file: cdi_deb_if.sv
// Carries the card-detect levels between the top and its debouncer.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface cdi_deb_if;
  logic [1:0] raw;
  logic [1:0] sync;
  logic [1:0] stable;
  modport filt (input raw, output sync, output stable);
  modport user (output raw, input sync, input stable);
endinterface : cdi_deb_if
`default_nettype wire

// file: cdi_debounce.sv
// Two-flop synchroniser and stability filter for the two card-detect pins.
// Assumes raw pin levels that are asynchronous to the system clock.
`timescale 1ns/1ps
`default_nettype none
module cdi_debounce
  import cdi_pkg::*;
#(
  parameter logic [15:0] P_DEBOUNCE_CYC = DEBOUNCE_CYC
) (
  input  wire logic i_clk_sys,
  input  wire logic i_reset_n,
  cdi_deb_if.filt   db
);

  logic [1:0]  sync1;
  logic [1:0]  sync2;
  logic [1:0]  stable;
  logic [15:0] cnt;
  logic [1:0]  last;
  logic [1:0]  next_stable;
  logic [15:0] next_cnt;

  // A new level must hold for the full count before it replaces the old one.
  always_comb begin
    next_stable = stable;
    next_cnt    = cnt;
    if (sync2 != last) begin
      next_cnt = 16'h0000;
    end else if (sync2 != stable) begin
      if (cnt >= P_DEBOUNCE_CYC - 16'h0001) begin
        next_stable = sync2;
        next_cnt    = 16'h0000;
      end else begin
        next_cnt = cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync1  <= DET_BOTH_HI;
      sync2  <= DET_BOTH_HI;
      last   <= DET_BOTH_HI;
      stable <= DET_BOTH_HI;
      cnt    <= 16'h0000;
    end else begin
      sync1  <= db.raw;
      sync2  <= sync1;
      last   <= sync2;
      stable <= next_stable;
      cnt    <= next_cnt;
    end
  end

  assign db.sync   = sync2;
  assign db.stable = stable;

endmodule : cdi_debounce
`default_nettype wire

// file: cdi_card_detect.sv
// Socket-side card detect, sense validation and card-type interrogation.
// Assumes detect pins pulled high off chip and sense pins with weak pull-ups.
`timescale 1ns/1ps
`default_nettype none
module cdi_card_detect
  import cdi_pkg::*;
#(
  parameter logic [15:0] P_DEBOUNCE_CYC = DEBOUNCE_CYC
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset_n,
  input  wire logic       i_five_volt_only,
  input  wire logic       i_typeb_enable,
  input  wire logic [3:0] i_supply_caps,
  input  wire logic [1:0] i_card_present_n,
  input  wire logic [1:0] i_volt_sense_in,
  output logic      [1:0] o_volt_sense_out,
  output logic      [1:0] o_volt_sense_oe,
  output logic      [3:0] o_vcc_sel,
  output logic      [3:0] o_vpp_sel,
  output logic            o_card_sig_en,
  output logic      [1:0] o_card_type,
  output logic      [3:0] o_supply_code,
  output logic            o_done,
  output logic            o_insert_event,
  output logic            o_reject_notify,
  output logic            o_misinsert_notify
);

  ////////////////////////////////////////////////////////////////////////////
  // Detect filtering and sense synchronisation.

  cdi_deb_if dbi ();
  assign dbi.raw = i_card_present_n;

  cdi_debounce #(.P_DEBOUNCE_CYC(P_DEBOUNCE_CYC)) u_deb (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .db        (dbi.filt)
  );

  logic [1:0] vs_s1;
  logic [1:0] vs_s2;

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      vs_s1 <= DET_BOTH_HI;
      vs_s2 <= DET_BOTH_HI;
    end else begin
      vs_s1 <= i_volt_sense_in;
      vs_s2 <= vs_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers.

  // Returns {type, supply}. A detect that follows a raised sense line is strapped to it.
  function automatic logic [5:0] decode(input logic [3:0] r1, input logic [3:0] r2);
    logic c11;
    logic c21;
    logic c12;
    logic c22;
    logic v1o;
    logic v1g;
    logic v2o;
    logic v2g;
    c11 = r1[SMP_CD1];
    c21 = r1[SMP_CD2];
    c12 = r2[SMP_CD1];
    c22 = r2[SMP_CD2];
    v1g = !r1[SMP_VS1];
    v1o = r1[SMP_VS1] && !c11 && !c21;
    v2g = !r2[SMP_VS2];
    v2o = r2[SMP_VS2] && !c12 && !c22;
    decode = {TYPE_RSVD, SUP_NONE};
    if (!(c11 || c21 || c12 || c22)) begin
      if (v2o && v1o)      decode = {TYPE_16BIT, SUP_5V};
      else if (v2o && v1g) decode = {TYPE_16BIT, SUP_5V | SUP_3V3};
      else if (v2g && v1g) decode = {TYPE_16BIT, SUP_5V | SUP_3V3 | SUP_XV};
      else if (v2g && v1o) decode = {TYPE_16BIT, SUP_XV};
    end else if (c11 && !c22 && !c12 && v2o) begin
      decode = {TYPE_B, SUP_3V3};
    end else if (c22 && v1g) begin
      decode = {TYPE_B, SUP_3V3 | SUP_XV};
    end else if (c21 && v2g) begin
      decode = {TYPE_B, SUP_3V3 | SUP_XV | SUP_YV};
    end else if (c22 && v1o) begin
      decode = {TYPE_B, SUP_XV};
    end else if (c12 && v1o) begin
      decode = {TYPE_B, SUP_XV | SUP_YV};
    end else if (c21 && v2o) begin
      decode = {TYPE_B, SUP_YV};
    end
  endfunction : decode

  // Highest requested level that the socket can also supply, or none.
  function automatic logic [3:0] pick(input logic [3:0] req);
    pick = SUP_NONE;
    for (int i = 3; i >= 0; i--) begin
      if (req[i]) pick = SUP_NONE | (4'h1 << i);
    end
  endfunction : pick

  ////////////////////////////////////////////////////////////////////////////
  // Insertion and interrogation sequencer.

  cdi_state_t state;
  cdi_state_t next_state;
  logic [3:0] tmr;
  logic [3:0] next_tmr;
  logic [3:0] smp1;
  logic [3:0] next_smp1;
  logic [3:0] smp2;
  logic [3:0] next_smp2;
  logic [3:0] next_vcc;
  logic [1:0] next_type;
  logic [3:0] next_code;
  logic       next_done;
  logic       next_event;
  logic       next_reject;
  logic       next_mis;
  logic [1:0] next_sense;
  logic [5:0] dec;
  logic       valid_ins;

  // Sense inputs are only believed while both detects are stably low.
  assign valid_ins = (dbi.stable == DET_BOTH_LO);
  assign dec       = decode(smp1, smp2);

  always_comb begin
    next_state  = state;
    next_tmr    = tmr;
    next_smp1   = smp1;
    next_smp2   = smp2;
    next_vcc    = o_vcc_sel;
    next_type   = o_card_type;
    next_code   = o_supply_code;
    next_done   = o_done;
    next_event  = 1'b0;
    next_reject = o_reject_notify;
    next_mis    = 1'b0;
    case (state)
      ST_IDLE: begin
        next_mis = !i_typeb_enable && (dbi.stable[0] != dbi.stable[1]);
        next_tmr = 4'h0;
        if (valid_ins) begin
          if (i_five_volt_only) begin
            next_vcc   = SUP_5V;
            next_type  = TYPE_16BIT;
            next_code  = SUP_5V;
            next_done  = 1'b1;
            next_event = 1'b1;
            next_state = ST_POWERED;
          end else if (i_typeb_enable) begin
            next_state = ST_PROBE1;
          end else begin
            // Sense lines float on their pull-ups here; one sample serves both probes.
            next_smp1  = {dbi.sync, vs_s2};
            next_smp2  = {dbi.sync, vs_s2};
            next_state = ST_DECIDE;
          end
        end
      end
      ST_PROBE1, ST_PROBE2: begin
        if (tmr == PROBE_CYC - 4'h1) begin
          next_tmr = 4'h0;
          if (state == ST_PROBE1) begin
            next_smp1  = {dbi.sync, vs_s2};
            next_state = ST_PROBE2;
          end else begin
            next_smp2  = {dbi.sync, vs_s2};
            next_state = ST_DECIDE;
          end
        end else begin
          next_tmr = tmr + 4'h1;
        end
      end
      ST_DECIDE: begin
        next_type  = i_typeb_enable ? dec[5:4] : TYPE_16BIT;
        next_code  = dec[3:0];
        next_vcc   = pick(dec[3:0] & i_supply_caps);
        next_done  = 1'b1;
        next_event = 1'b1;
        if (pick(dec[3:0] & i_supply_caps) == SUP_NONE) begin
          next_reject = 1'b1;
          next_state  = ST_REJECT;
        end else begin
          next_state = ST_POWERED;
        end
      end
      ST_POWERED, ST_REJECT: begin
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // Removal tears everything down without software.
    if (!valid_ins && state != ST_IDLE) begin
      next_state  = ST_IDLE;
      next_vcc    = SUP_NONE;
      next_type   = TYPE_NONE;
      next_code   = SUP_NONE;
      next_done   = 1'b0;
      next_event  = 1'b0;
      next_reject = 1'b0;
    end
    case (next_state)
      ST_PROBE1: next_sense = SENSE_HI1;
      ST_PROBE2: next_sense = SENSE_HI2;
      default:   next_sense = SENSE_LOW;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state              <= ST_IDLE;
      tmr                <= 4'h0;
      smp1               <= 4'h0;
      smp2               <= 4'h0;
      o_vcc_sel          <= SUP_NONE;
      o_card_type        <= TYPE_NONE;
      o_supply_code      <= SUP_NONE;
      o_done             <= 1'b0;
      o_insert_event     <= 1'b0;
      o_reject_notify    <= 1'b0;
      o_misinsert_notify <= 1'b0;
      o_volt_sense_out   <= SENSE_LOW;
    end else begin
      state              <= next_state;
      tmr                <= next_tmr;
      smp1               <= next_smp1;
      smp2               <= next_smp2;
      o_vcc_sel          <= next_vcc;
      o_card_type        <= next_type;
      o_supply_code      <= next_code;
      o_done             <= next_done;
      o_insert_event     <= next_event;
      o_reject_notify    <= next_reject;
      o_misinsert_notify <= next_mis;
      o_volt_sense_out   <= next_sense;
    end
  end

  // Programming supplies follow the selected supply; nothing in this block retunes them.
  assign o_vpp_sel       = o_vcc_sel;
  // Card signals are only driven once the card is powered.
  assign o_card_sig_en   = (o_vcc_sel != SUP_NONE);
  // A 16-bit-only socket leaves its sense lines to the pull-ups.
  assign o_volt_sense_oe = i_typeb_enable ? DET_BOTH_HI : DET_BOTH_LO;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  sequence s_probe1;
    (o_volt_sense_out == SENSE_HI1)[*5];
  endsequence
  sequence s_probe2;
    (o_volt_sense_out == SENSE_HI2)[*5];
  endsequence

  five_volt_a: assert property (o_vcc_sel != SUP_NONE && i_five_volt_only
    && $stable(i_five_volt_only) && $past(state) == ST_IDLE
    |-> o_vcc_sel == SUP_5V) else $error("5 V socket wrong supply");
  removal_off_a: assert property (!valid_ins && state != ST_IDLE
    |=> o_vcc_sel == SUP_NONE && !o_card_sig_en ##1 o_vcc_sel == SUP_NONE)
    else $error("supply kept after removal");
  power_valid_a: assert property ($rose(o_card_sig_en) |-> $past(valid_ins))
    else $error("powered without both detects");
  supply_ok_a: assert property (o_vcc_sel != SUP_NONE && !i_five_volt_only
    |-> (o_vcc_sel & o_supply_code) == o_vcc_sel) else $error("supply not requested");
  reject_off_a: assert property (o_reject_notify
    |-> o_vcc_sel == SUP_NONE && !o_card_sig_en) else $error("rejected card powered");
  misinsert_a: assert property (o_misinsert_notify
    |-> !i_typeb_enable && state == ST_IDLE) else $error("misinsert flag outside idle");
  insert_valid_a: assert property (state == ST_IDLE ##1 state != ST_IDLE
    |-> $past(valid_ins)) else $error("insertion without both detects");
  sense_low_a: assert property (state == ST_IDLE && i_typeb_enable
    |-> o_volt_sense_out == SENSE_LOW && o_volt_sense_oe == DET_BOTH_HI)
    else $error("sense not driven low while idle");
  probe_seq_a: assert property ($rose(state == ST_PROBE1)
    |-> s_probe1 ##1 s_probe2 or ##[0:9] state == ST_IDLE) else $error("probe sequence wrong");
  sense_rest_a: assert property (state != ST_PROBE1 && state != ST_PROBE2
    |-> o_volt_sense_out == SENSE_LOW) else $error("sense high outside probe");
  event_done_a: assert property (o_insert_event
    |-> o_done && o_card_type != TYPE_NONE) else $error("insertion event before type known");
  vpp_same_a: assert property (o_card_sig_en |-> o_vpp_sel == o_vcc_sel)
    else $error("programming supply differs");

endmodule : cdi_card_detect
`default_nettype wire

// file: cdi_card_model.sv
// Behavioural card in a socket: detect and sense straps resolved to pin levels.
// Assumes socket pull-ups on all four pins and sense drivers weaker than a ground strap.
`timescale 1ns/1ps
`default_nettype none
module cdi_card_model (
  input  wire logic [1:0] i_contact,
  input  wire logic [5:0] i_strap,
  input  wire logic [1:0] i_sense_out,
  input  wire logic [1:0] i_sense_oe,
  output logic      [1:0] o_card_present_n,
  output logic      [1:0] o_volt_sense_in
);
  // Strap word {detect2 tie, detect1 tie, sense grounded}; tie 0 ground, 1 sense1, 2 sense2.
  logic [1:0] tie;

  // The card answers no read or write cycle at all, so nothing it holds is seen.
  // With no reset pin the card always sits in its default power-on state.
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      o_volt_sense_in[k] = (|i_contact && i_strap[k]) ? 1'b0 :
                           (i_sense_oe[k] ? i_sense_out[k] : 1'b1);
    end
    for (int k = 0; k < 2; k++) begin
      tie = i_strap[2*k+2 +: 2];
      if (!i_contact[k]) begin
        o_card_present_n[k] = 1'b1;
      end else if (tie == 2'h0) begin
        o_card_present_n[k] = 1'b0;
      end else begin
        o_card_present_n[k] = o_volt_sense_in[tie[1]];
      end
    end
  end
endmodule : cdi_card_model
`default_nettype wire

// file: cdi_card_detect_test.sv
// Self-checking bench for the card detect block against a behavioural card.
// Assumes a short debounce count so each insertion takes a few dozen cycles.
`timescale 1ns/1ps
`default_nettype none
module cdi_card_detect_test;
  import cdi_pkg::*;
  // The count must outlast one probe phase, or a detect strapped to a raised sense line
  // is filtered into a removal and the card is torn down mid-interrogation.
  localparam logic [15:0] DEB = 16'h0010;
  logic       clk     = 1'b0;
  logic       rst_n   = 1'b0;
  logic       fvo     = 1'b0;
  logic       tbe     = 1'b1;
  logic [3:0] caps    = 4'hF;
  logic [1:0] contact = 2'h0;
  logic [5:0] strap   = 6'h00;
  logic [1:0] present_n, sense_in, sense_out, sense_oe, ctype;
  logic [3:0] vcc, vpp, code;
  logic       sig_en, done, ev, rej, mis;
  logic       prev_done = 1'b0;
  int         n_errors = 0;
  int         comparisons = 0;
  // Entries {strap, type, code} covering every listed card encoding.
  logic [11:0] tab [12] = '{12'h011, 12'h053, 12'h0D7, 12'h094, 12'h122, 12'h866,
                            12'h4AE, 12'h824, 12'h22C, 12'h428, 12'h1B0, 12'h270};

  always #50 clk = ~clk;

  cdi_card_detect #(.P_DEBOUNCE_CYC(DEB)) dut (
    .i_clk_sys(clk), .i_reset_n(rst_n), .i_five_volt_only(fvo), .i_typeb_enable(tbe),
    .i_supply_caps(caps), .i_card_present_n(present_n), .i_volt_sense_in(sense_in),
    .o_volt_sense_out(sense_out), .o_volt_sense_oe(sense_oe), .o_vcc_sel(vcc),
    .o_vpp_sel(vpp), .o_card_sig_en(sig_en), .o_card_type(ctype), .o_supply_code(code),
    .o_done(done), .o_insert_event(ev), .o_reject_notify(rej), .o_misinsert_notify(mis)
  );
  cdi_card_model card (
    .i_contact(contact), .i_strap(strap), .i_sense_out(sense_out), .i_sense_oe(sense_oe),
    .o_card_present_n(present_n), .o_volt_sense_in(sense_in)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk_bit(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s got %b want %b", $time, what, got, exp);
    end
  endtask : chk_bit

  task automatic chk_val(input logic [3:0] got, input logic [3:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk_val

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  // A reset pulse between scenarios is the only safe way to change the static socket settings (five-volt-only, type-B enable, supply caps).
  task automatic restart(input logic f, input logic t, input logic [3:0] c);
    rst_n = 1'b0;
    contact = 2'h0;
    fvo = f;
    tbe = t;
    caps = c;
    tick(2);
    rst_n = 1'b1;
    tick(2);
  endtask : restart

  task automatic wait_end(input int lim);
    int i;
    i = 0;
    while (done !== 1'b1 && rej !== 1'b1 && vcc === 4'h0 && i < lim) begin
      tick(1);
      i++;
    end
    chk_bit(i < lim, 1'b1, "no verdict");
  endtask : wait_end

  task automatic probe_walk;
    int i;
    i = 0;
    while (sense_out !== 2'h1 && i < 40) begin
      tick(1);
      i++;
    end
    for (int k = 0; k < 10; k++) begin
      chk_val({2'h0, sense_out}, (k < 5) ? 4'h1 : 4'h2, "probe");
      chk_val(vcc, 4'h0, "vcc early");
      tick(1);
    end
    chk_val({2'h0, sense_out}, 4'h0, "probe end");
  endtask : probe_walk

  task automatic remove_card;
    contact = 2'h0;
    tick(int'(DEB) + 6);
    chk_val(vcc, 4'h0, "vcc off");
    chk_bit(sig_en, 1'b0, "signals off");
    chk_val({2'h0, sense_out}, 4'h0, "sense low");
    chk_val({2'h0, sense_oe}, {2'h0, tbe, tbe}, "sense drive");
    chk_bit(done | rej, 1'b0, "flags clear");
    chk_val({2'h0, ctype}, 4'h0, "type clear");
  endtask : remove_card

  task automatic card_run(input logic [5:0] s, input logic [1:0] et, input logic [3:0] ec);
    logic [3:0] sel;
    sel = ec & caps;
    strap = s;
    contact = 2'h3;
    if (tbe) probe_walk();
    wait_end(40);
    chk_val({2'h0, ctype}, {2'h0, et}, "type");
    chk_val(code, ec, "code");
    chk_val(vcc, sel & (~sel + 4'h1), "vcc");
    chk_bit(rej, sel == 4'h0, "reject");
    remove_card();
  endtask : card_run

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_encodings;
    restart(1'b0, 1'b1, 4'hF);
    foreach (tab[k]) card_run(tab[k][11:6], tab[k][5:4], tab[k][3:0]);
    $display("test encodings done");
  endtask : t_encodings

  task automatic t_caps;
    restart(1'b0, 1'b1, 4'hE);
    card_run(6'h01, 2'h1, 4'h3);
    card_run(6'h00, 2'h1, 4'h1);
    restart(1'b0, 1'b1, 4'h8);
    card_run(6'h12, 2'h2, 4'hE);
    $display("test caps done");
  endtask : t_caps

  task automatic t_partial;
    restart(1'b0, 1'b1, 4'hF);
    strap = 6'h00;
    for (int k = 1; k < 3; k++) begin
      contact = 2'(k);
      tick(40);
      chk_bit(done | rej, 1'b0, "partial");
      chk_val({2'h0, sense_out}, 4'h0, "partial sense");
    end
    contact = 2'h3;
    tick(int'(DEB) - 1);
    contact = 2'h0;
    tick(30);
    chk_val(vcc, 4'h0, "short glitch");
    $display("test partial done");
  endtask : t_partial

  task automatic t_sixteen;
    restart(1'b0, 1'b0, 4'hF);
    chk_val({2'h0, sense_oe}, 4'h0, "no sense drive");
    strap = 6'h00;
    contact = 2'h2;
    tick(int'(DEB) + 10);
    chk_bit(mis, 1'b1, "misinsert");
    chk_val(vcc, 4'h0, "misinsert vcc");
    card_run(6'h00, 2'h1, 4'h1);
    chk_bit(mis, 1'b0, "misinsert clear");
    $display("test sixteen done");
  endtask : t_sixteen

  task automatic t_five;
    restart(1'b1, 1'b0, 4'h1);
    strap = 6'h02;
    contact = 2'h3;
    wait_end(40);
    chk_val(vcc, SUP_5V, "five volt");
    remove_card();
    $display("test five done");
  endtask : t_five

  ////////////////////////////////////////////////////////////////////////////////
  always begin
    @(posedge clk);
    #2;
    if (rst_n) begin
      chk_val(vpp, vcc, "vpp");
      chk_bit(sig_en, vcc != 4'h0, "sig_en");
      chk_bit(ev, done & ~prev_done, "event");
      if (ev) chk_bit(ctype != 2'h0, 1'b1, "event type");
      if (done | rej) chk_val({2'h0, sense_out}, 4'h0, "sense idle");
    end
    prev_done = done;
  end

  initial begin
    #2000000;
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    tick(20);
    rst_n = 1'b1;
    tick(2);
    t_encodings();
    t_caps();
    t_partial();
    t_sixteen();
    t_five();
    end_of_test();
  end
endmodule : cdi_card_detect_test
`default_nettype wire
